// file: hw/bdio_field_path.sv
// Per-channel driver control and comparator source selection of the I/O port.
`default_nettype none

module bdio_field_path
    import bdio_pkg::*;
#(
    parameter bit POS_TRUE = 1'b1,
    parameter bit DIR_CTRL = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [31:0] outputLatch,
    input  wire logic        driverDisable_n,
    input  wire logic        testBufferEnable_n,
    input  wire logic [3:0]  byteDir,
    input  wire logic [31:0] fieldIn,
    output var  logic [31:0] fieldOut,
    output var  logic [31:0] fieldOe,
    output var  logic [31:0] compVal
);

    logic [31:0] chanEnable;
    logic [31:0] driverOn;
    logic        offLine;

    // Direction bit 0 governs channels 24-31, bit 3 governs channels 0-7.
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            chanEnable[8*b +: 8] = {8{driverDisable_n & (DIR_CTRL ? byteDir[3-b] : 1'b1)}};
        end
    end

    // A non-inverting latch turns the driver off for a one.
    assign driverOn = POS_TRUE ? ~outputLatch : outputLatch;

    // Off-line loopback only when both mode bits are active.
    assign offLine = ~driverDisable_n & ~testBufferEnable_n;

    // Off-line returns the latch, otherwise the comparators see the pins.
    assign compVal = offLine ? outputLatch : fieldIn;

    // An open-collector driver only ever pulls low.
    assign fieldOut = '0;

    // Driver enables follow the latch, gated by mode and direction.
    always_ff @(posedge clk) begin
        if (rst) begin
            fieldOe <= '0;
        end else begin
            fieldOe <= chanEnable & driverOn;
        end
    end

endmodule : bdio_field_path

`default_nettype wire

// file: hw/bdio_top.sv
// Bus digital I/O port with loopback test, reached as an AHB-Lite slave.
`default_nettype none

// Summary of operation
// - Control bit turns fail indicator off or on.
// - Read-only identification byte follows polarity option.
// - Writes load output latch, latch drives drivers.
// - Inverting latch: one drives low; positive-true opposite.
// - Read latches comparator outputs, returns latched value.
// - Two active-low mode bits select three modes.
// - Off-line: drivers disabled, test buffers enabled.
// - Reset enters off-line test mode.
// - Off-line: written data loops back to reads.
// - On-line: reads show output pin state.
// - Normal: reads always show output pin state.
// - Output and input latches share one address.
// - Decoded cycle routes data to addressed register.
// - Acknowledge only after the access completes.
// - Byte, halfword and word transfers accepted.
// - Direction bits enable channel bytes as outputs.
// - Status word: identification high, control low.
// - Byte zero holds channels 31-24, byte three 7-0.
module bdio_top
    import bdio_pkg::*;
#(
    parameter bit         POS_TRUE    = 1'b1,
    parameter bit         DIR_CTRL    = 1'b0,
    parameter logic [7:0] ID_POS_TRUE = 8'h3C, // Arbitrary value.
    parameter logic [7:0] ID_NEG_TRUE = 8'hC3  // Arbitrary value.
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    input  wire logic [31:0] fieldIn,
    output var  logic [31:0] fieldOut,
    output var  logic [31:0] fieldOe,
    output var  logic        failLedOn,
    output var  logic        testBufferOn
);

    // The two option parameters must give different identification bytes.
    if (ID_POS_TRUE == ID_NEG_TRUE) begin : g_id_check
        $error("bdio_top: the two identification values must differ.");
    end

    bdio_bus_e   busState_reg;
    bdio_bus_e   busState_next;
    logic [7:0]  reqAddr_reg;
    logic        reqWrite_reg;
    logic [3:0]  reqLanes_reg;
    logic [31:0] outputLatch_reg;
    logic [31:0] rdata_reg;
    logic [7:0]  ctrl_reg;
    logic        failLedOn_reg;
    logic        testBufferOn_reg;
    logic        addrPhase;
    logic        hitData;
    logic        hitCsr;
    logic [31:0] compVal;
    logic [31:0] laneBits;
    logic [7:0]  ctrlImage;
    logic [7:0]  ctrlFromBus;
    logic [7:0]  boardId;
    logic [31:0] mergedBus;
    logic [15:0] statusWord;

    // A transfer is taken when the master presents a selected non-sequential phase.
    assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);

    // Decoding of the captured address into the two register words.
    assign hitData = (reqAddr_reg == DATA_OFS);
    assign hitCsr  = (reqAddr_reg == CSR_OFS);

    // Lanes of the pending transfer expanded to bit positions.
    assign laneBits = bdioBitMask(reqLanes_reg);

    // Identification byte depends on the polarity option.
    assign boardId = POS_TRUE ? ID_POS_TRUE : ID_NEG_TRUE;

    // Control bits are stored in true sense and flipped on the bus for
    // the negative-true option, so reset always lands in off-line mode.
    always_comb begin
        ctrlImage = POS_TRUE ? ctrl_reg : ~ctrl_reg;
        ctrlImage[CSR_UNUSED_BIT] = 1'b0;
        ctrlFromBus = POS_TRUE ? hwdata[7:0] : ~hwdata[7:0];
        ctrlFromBus[CSR_UNUSED_BIT] = 1'b0;
    end

    // Status word as read: identification above, control below.
    assign statusWord = {boardId, ctrlImage};

    // New output word with only the addressed byte lanes replaced.
    assign mergedBus = (bdioLaneSwap(outputLatch_reg) & ~laneBits) | (hwdata & laneBits);

    // Data phase sequencer: one wait state, then the answer.
    always_comb begin
        busState_next = busState_reg;
        case (busState_reg)
            BDIO_IDLE: begin
                if (addrPhase) begin
                    busState_next = BDIO_WAIT;
                end
            end
            BDIO_WAIT: begin
                busState_next = BDIO_DONE;
            end
            BDIO_DONE: begin
                busState_next = addrPhase ? BDIO_WAIT : BDIO_IDLE;
            end
            default: begin
                busState_next = BDIO_IDLE;
            end
        endcase
    end

    // State register of the sequencer.
    always_ff @(posedge clk) begin
        if (rst) begin
            busState_reg <= BDIO_IDLE;
        end else begin
            busState_reg <= busState_next;
        end
    end

    // Address phase capture of the pending request.
    always_ff @(posedge clk) begin
        if (rst) begin
            reqAddr_reg  <= '0;
            reqWrite_reg <= 1'b0;
            reqLanes_reg <= '0;
        end else if (addrPhase && (busState_reg != BDIO_WAIT)) begin
            reqAddr_reg  <= {haddr[DEC_ADDR_W-1:2], 2'b00};
            reqWrite_reg <= hwrite;
            reqLanes_reg <= bdioLaneMask(hsize, haddr[1:0]);
        end
    end

    // Output latch written from the bus in the wait cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            outputLatch_reg <= LATCH_RST;
        end else if ((busState_reg == BDIO_WAIT) && reqWrite_reg && hitData) begin
            outputLatch_reg <= bdioLaneSwap(mergedBus);
        end
    end

    // Control bits, writable only through the low byte of the status word.
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= CSR_CTRL_RST;
        end else if ((busState_reg == BDIO_WAIT) && reqWrite_reg && hitCsr
                     && reqLanes_reg[0]) begin
            ctrl_reg <= ctrlFromBus;
        end
    end

    // Read data register, which is also the input latch: a data read snapshots
    // the comparators here and the bus is driven from that snapshot.
    // An unmapped word reads as zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= '0;
        end else if ((busState_reg == BDIO_WAIT) && !reqWrite_reg) begin
            if (hitData) begin
                rdata_reg <= bdioLaneSwap(compVal);
            end else if (hitCsr) begin
                rdata_reg <= {16'h0000, statusWord};
            end else begin
                rdata_reg <= '0;
            end
        end
    end

    // Indicator and test-buffer state registered for the outputs.
    always_ff @(posedge clk) begin
        if (rst) begin
            failLedOn_reg    <= 1'b1;
            testBufferOn_reg <= 1'b1;
        end else begin
            failLedOn_reg    <= ~ctrl_reg[CSR_FAIL_OFF_BIT];
            testBufferOn_reg <= ~ctrl_reg[CSR_TB_EN_N_BIT];
        end
    end

    // Channel drivers and comparator source under the mode bits.
    bdio_field_path #(
        .POS_TRUE (POS_TRUE),
        .DIR_CTRL (DIR_CTRL)
    ) u_field (
        .clk                (clk),
        .rst                (rst),
        .outputLatch        (outputLatch_reg),
        .driverDisable_n    (ctrl_reg[CSR_DRV_DIS_N_BIT]),
        .testBufferEnable_n (ctrl_reg[CSR_TB_EN_N_BIT]),
        .byteDir            (ctrl_reg[CSR_DIR_LSB +: 4]),
        .fieldIn            (fieldIn),
        .fieldOut           (fieldOut),
        .fieldOe            (fieldOe),
        .compVal            (compVal)
    );

    // Bus answers: ready drops only in the wait cycle, response always OKAY.
    assign hreadyout    = (busState_reg != BDIO_WAIT);
    assign hresp        = 1'b0;
    assign hrdata       = rdata_reg;
    assign failLedOn    = failLedOn_reg;
    assign testBufferOn = testBufferOn_reg;

endmodule : bdio_top

`default_nettype wire

// file: include/bdio_pkg.sv
// Shared constants, types and helper functions for the bus digital I/O port.
`default_nettype none

package bdio_pkg;

    // Register byte offsets inside the slave's window.
    localparam int unsigned     DEC_ADDR_W   = 8;
    localparam logic [7:0]      DATA_OFS     = 8'h00;
    localparam logic [7:0]      CSR_OFS      = 8'h04;

    // Field positions of the control/status word.
    localparam int unsigned     CSR_DIR_LSB      = 0;
    localparam int unsigned     CSR_UNUSED_BIT   = 4;
    localparam int unsigned     CSR_FAIL_OFF_BIT = 5;
    localparam int unsigned     CSR_TB_EN_N_BIT  = 6;
    localparam int unsigned     CSR_DRV_DIS_N_BIT = 7;
    localparam int unsigned     CSR_ID_LSB       = 8;

    // Values after reset.
    localparam logic [7:0]      CSR_CTRL_RST = 8'h00;
    localparam logic [31:0]     LATCH_RST    = 32'h0000_0000;

    // Bus encodings used by the slave.
    localparam logic [1:0]      HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]      HSIZE_BYTE    = 3'h0;
    localparam logic [2:0]      HSIZE_HALF    = 3'h1;

    // Data phase sequencing of the slave.
    typedef enum logic [1:0] {
        BDIO_IDLE,
        BDIO_WAIT,
        BDIO_DONE
    } bdio_bus_e;

    // Byte lane k of the bus word carries channels 31-8k down to 24-8k.
    function automatic logic [31:0] bdioLaneSwap(input logic [31:0] x);
        bdioLaneSwap = {x[7:0], x[15:8], x[23:16], x[31:24]};
    endfunction : bdioLaneSwap

    // Lanes touched by a transfer of the given size at the given address.
    function automatic logic [3:0] bdioLaneMask(input logic [2:0] size,
                                                input logic [1:0] addr);
        if (size == HSIZE_BYTE) begin
            bdioLaneMask = 4'(4'h1 << addr);
        end else if (size == HSIZE_HALF) begin
            bdioLaneMask = addr[1] ? 4'hC : 4'h3;
        end else begin
            bdioLaneMask = 4'hF;
        end
    endfunction : bdioLaneMask

    // Widens a lane mask to a bit mask.
    function automatic logic [31:0] bdioBitMask(input logic [3:0] lanes);
        bdioBitMask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
    endfunction : bdioBitMask

endpackage : bdio_pkg

`default_nettype wire

// file: test/bdio_ahb_master.sv
// Bus master model that issues single byte, halfword or word transfers to the I/O port.
`default_nettype none

module bdio_ahb_master (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output var  logic        hsel,
    output var  logic [31:0] haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // The bus starts idle.
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // One transfer; entered just after a rising edge, returns just after one.
    task automatic xfer(input logic w, input logic [31:0] a, input logic [2:0] sz,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= sz;
        do @(negedge clk); while (hready !== 1'b1);
        @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(negedge clk); while (hready !== 1'b1);
        rd = hrdata;
        @(posedge clk);
        hwdata <= ~wd;
    endtask : xfer

endmodule : bdio_ahb_master

`default_nettype wire

// file: test/bdio_props.sv
// Concurrent checks on the ports of the bus digital I/O port.
`default_nettype none

module bdio_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] fieldOut,
    input wire logic [31:0] fieldOe,
    input wire logic        failLedOn,
    input wire logic        testBufferOn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       taken;
    logic [2:0] wrAge;
    logic [2:0] rdAge;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // A transfer is accepted on an edge with select, ready and a start code.
    assign taken = hsel && hready && (htrans == 2'h2);

    // Edges since the last accepted write, saturating at seven.
    always_ff @(posedge clk) begin
        if (rst || (taken && hwrite)) begin
            wrAge <= rst ? 3'h7 : 3'h0;
        end else if (wrAge != 3'h7) begin
            wrAge <= wrAge + 3'h1;
        end
    end

    // Edges since the last accepted read, saturating at seven.
    always_ff @(posedge clk) begin
        if (rst || (taken && !hwrite)) begin
            rdAge <= rst ? 3'h7 : 3'h0;
        end else if (rdAge != 3'h7) begin
            rdAge <= rdAge + 3'h1;
        end
    end

    // The slave stalls for one cycle, then completes.
    sequence sWaitOne;
        !hreadyout ##1 hreadyout;
    endsequence

    AST_ONE_WAIT: assert property (taken |=> sWaitOne)
        else $error("transfer did not see exactly one wait cycle");
    AST_WAIT_CAUSE: assert property (!hreadyout |-> $past(taken))
        else $error("wait cycle without an accepted transfer");
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("response was not okay");
    AST_PULL_LOW: assert property (fieldOut == 32'h0)
        else $error("open collector pin driven high");
    AST_RESET_OFFLINE: assert property ($fell(rst) |-> failLedOn && testBufferOn && (fieldOe == 32'h0))
        else $error("not off-line after reset");
    AST_OE_CAUSE: assert property ($changed(fieldOe) |-> wrAge <= 3'h3)
        else $error("driver enables changed without a write");
    AST_CTRL_CAUSE: assert property ($changed({failLedOn, testBufferOn}) |-> wrAge <= 3'h3)
        else $error("indicator or buffers changed without a write");
    AST_RDATA_CAUSE: assert property ($changed(hrdata) |-> rdAge <= 3'h2)
        else $error("read data changed without a read");

endmodule : bdio_props

bind bdio_top bdio_props u_props (.clk(clk), .rst(rst), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fieldOut(fieldOut), .fieldOe(fieldOe), .failLedOn(failLedOn),
    .testBufferOn(testBufferOn));

`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the bus digital I/O port.
`default_nettype none

module testbench
    import bdio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0]  ID   = 8'h3C; // Arbitrary value.
    localparam logic [31:0] BUSW = 32'hCDEFAB78;
    logic        clk, rst, hsel, hwrite, hreadyout, hresp, failLedOn, testBufferOn;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, fieldIn, fieldOut, fieldOe, extIn;
    logic [31:0] hrdataNeg, fieldInNeg, fieldOeNeg;
    logic        failLedNeg;
    int          miscompares = 0;
    int          checks = 0;

    // Pins idle high through the pull-up; a driver or the field pulls low.
    assign fieldIn = ~fieldOe & extIn;
    assign fieldInNeg = ~fieldOeNeg & extIn;

    // Clock generator.
    always #2 clk = ~clk;

    bdio_top #(.POS_TRUE(1'b1), .DIR_CTRL(1'b1), .ID_POS_TRUE(ID), .ID_NEG_TRUE(~ID)) dut (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .fieldIn(fieldIn), .fieldOut(fieldOut),
        .fieldOe(fieldOe), .failLedOn(failLedOn), .testBufferOn(testBufferOn));

    bdio_ahb_master u_mst (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // Negative-true twin without direction control; it runs in step on the same bus.
    bdio_top #(.POS_TRUE(1'b0), .DIR_CTRL(1'b0), .ID_POS_TRUE(ID), .ID_NEG_TRUE(~ID)) dutNeg (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdataNeg),
        .hreadyout(), .hresp(), .fieldIn(fieldInNeg), .fieldOut(),
        .fieldOe(fieldOeNeg), .failLedOn(failLedNeg), .testBufferOn());

    // Channel image of a bus word: lane 0 carries channels 31 to 24.
    function automatic logic [31:0] swp(input logic [31:0] x);
        swp = {x[7:0], x[15:8], x[23:16], x[31:24]};
    endfunction : swp

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [2:0] sz, input logic [31:0] d);
        logic [31:0] t;
        u_mst.xfer(1'b1, {24'h0, a}, sz, d, t);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] g;
        u_mst.xfer(1'b0, {24'h0, a}, 3'h2, 32'h0, g);
        chk("hrdata", e, g);
    endtask : rdc

    // Lets pin outputs settle, then compares them.
    task automatic pins(input logic [31:0] oe, input logic led, input logic tb);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("fieldOe", oe, fieldOe);
        chk("failLedOn", {31'h0, led}, {31'h0, failLedOn});
        chk("testBufferOn", {31'h0, tb}, {31'h0, testBufferOn});
        @(posedge clk);
    endtask : pins

    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // Watchdog against a hung handshake.
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        finish_test();
    end

    // Main test sequence.
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        extIn = 32'hFFFF_FFFF;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        pins(32'h0, 1'b1, 1'b1);
        rdc(CSR_OFS, {16'h0, ID, 8'h00});
        chk("hrdataNeg", {16'h0, ~ID, 8'hEF}, hrdataNeg);
        $display("test reset done");
        wr(DATA_OFS, 3'h2, 32'h12345678);
        rdc(DATA_OFS, 32'h12345678);
        wr(8'h01, 3'h0, 32'h0000AB00);
        wr(8'h02, 3'h1, 32'hCDEF0000);
        rdc(DATA_OFS, BUSW);
        pins(32'h0, 1'b1, 1'b1);
        $display("test loopback done");
        wr(CSR_OFS, 3'h2, 32'hFFFF_FFFF);
        rdc(CSR_OFS, {16'h0, ID, 8'hEF});
        pins(~swp(BUSW), 1'b0, 1'b0);
        rdc(DATA_OFS, BUSW);
        extIn <= 32'hFFFF_0000;
        rdc(DATA_OFS, swp(swp(BUSW) & 32'hFFFF_0000));
        wr(CSR_OFS, 3'h2, 32'h000000E1);
        pins(~swp(BUSW) & 32'hFF00_0000, 1'b0, 1'b0);
        $display("test normal done");
        wr(CSR_OFS, 3'h2, 32'h0000008F);
        pins(~swp(BUSW), 1'b1, 1'b1);
        rdc(DATA_OFS, swp(swp(BUSW) & 32'hFFFF_0000));
        wr(CSR_OFS, 3'h0, 32'h0000000F);
        pins(32'h0, 1'b1, 1'b1);
        chk("fieldOeNeg", swp(BUSW), fieldOeNeg);
        chk("failLedNeg", 32'h0, {31'h0, failLedNeg});
        rdc(DATA_OFS, BUSW);
        chk("hrdataNeg", ~BUSW & 32'h0000_FFFF, hrdataNeg);
        rdc(8'h08, 32'h0);
        $display("test online done");
        wr(CSR_OFS, 3'h2, 32'h000000EF);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(CSR_OFS, {16'h0, ID, 8'h00});
        pins(32'h0, 1'b1, 1'b1);
        rdc(DATA_OFS, 32'h0);
        $display("test rereset done");
        finish_test();
    end

endmodule : testbench

`default_nettype wire
